/* rtl/tag_fifo_irq_command_ctrl.v */
// Purpose: Serial-side FIFO, interrupt registers and direct commands of a passive tag
// Assumes: Serial pins and link clock are asynchronous and synchronised here
// Notes:   Summary of operation
// Summary of operation
// RULE1: Main register: seven sources plus aux-pending flag
// RULE2: Any event sets flag and raises irq
// RULE3: Reading a register clears it, except aux-pending
// RULE4: Aux-pending clears only on auxiliary read; code also clears it on set_default (C2/C3)
// RULE5: Irq drops once all causing flags read
// RULE6: Transmit water level at 8 bytes left
// RULE7: Receive water level at 24 bytes stored
// RULE8: Water level blocked during serial FIFO access
// RULE9: FIFO access lasts while select stays low
// RULE10: Underflow interrupt never blocked during load
// RULE11: Level met at end gives interrupt
// RULE12: Level unmet at end gives none
// RULE13: Status reports unread FIFO byte count
// RULE14: Writing into full FIFO sets overflow
// RULE15: Taking from empty FIFO sets underflow
// RULE16: Byte framing checks, strips, generates parity
// RULE17: Air b1 maps D0, bits reversed
// RULE18: Bit-stream keeps order, zero pads tail
// RULE19: C2/C3 restore power-up defaults
// RULE20: C4/C5 abort activity, empty FIFO
// RULE21: C8 transmits only in field, Level-4; code also starts it in modes 2 and 3
// RULE22: D0 halts only in field, protocol mode
// RULE23: Mode 10 code 0 loads, code 3f reads
// RULE24: Mode 11 byte is direct command
// RULE25: Bit-stream options skip parity and CRC
`timescale 1ns/1ps
`include "tag_fifo_consts.vh"
module tag_fifo_irq_command_ctrl #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire       core_clk,                 // 125 MHz clock
  input  wire       sys_rst,                  // Sync reset, active high
  input  wire       clk_en,                   // Freezes state when low
  input  wire       ss_n,                     // Slave select pin, active low
  input  wire       sclk,                     // Serial link clock pin
  input  wire       mosi,                     // Serial data in pin
  output reg        miso,                     // Serial data out
  output reg        miso_oe,                  // Serial data out enable
  output wire       irq,                      // Interrupt request
  input  wire       rd_main_irq,              // Pulse: main register read
  input  wire       rd_aux_irq,               // Pulse: auxiliary register read
  output reg  [7:0] main_irq,                 // Main interrupt register
  output reg  [7:0] aux_irq,                  // Auxiliary interrupt register
  input  wire [6:0] main_irq_event,           // Other main interrupt sources
  output wire [7:0] fifo_status1,             // Unread byte count
  output wire [7:0] fifo_status2,             // Overflow, underflow
  input  wire [1:0] proto_mode,               // Protocol mode select
  input  wire       rx_bitstream,             // Receive bit-stream option
  input  wire       tx_bitstream,             // Transmit bit-stream option
  input  wire       field_power_on_threshold, // Field supply above threshold
  input  wire [5:0] tx_byte_count,            // Bytes to transmit
  input  wire [8:0] rx_air_byte,              // Air byte, b1 at bit 0, parity at 8
  input  wire [3:0] rx_air_bits,              // Valid bits, 8 for full byte
  input  wire       rx_air_valid,             // Air byte strobe
  output wire       rx_air_ready,             // Receive path accepts
  output reg  [8:0] tx_air_byte,              // Byte with parity to framing
  output reg        tx_air_valid,             // Transmit byte strobe
  input  wire       tx_air_ready,             // Framing takes the byte
  output reg        tx_active,                // Transmission running
  output reg        enter_halt_command,       // Pulse: enter HALT
  output reg        set_default               // Pulse: registers to defaults
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_HEAD = 4'h2;
  localparam [3:0] S_LOAD = 4'h4;
  localparam [3:0] S_READ = 4'h8;

  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
        rev8[k] = v[7-k];
    end
  endfunction

  reg [2:0] ss_s;
  reg [2:0] sclk_s;
  reg [1:0] mosi_s;
  wire      ss_low   = ~ss_s[1];
  wire      ss_rise  = ss_s[1] & ~ss_s[2];
  wire      sclk_ris = sclk_s[1] & ~sclk_s[2];
  wire      sclk_fal = ~sclk_s[1] & sclk_s[2];

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ss_s   <= 3'h7;
      sclk_s <= 3'h0;
      mosi_s <= 2'h0;
    end else if (clk_en) begin
      ss_s   <= {ss_s[1:0], ss_n};
      sclk_s <= {sclk_s[1:0], sclk};
      mosi_s <= {mosi_s[0], mosi};
    end
  end

  reg  [7:0]    mem [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [AW:0]   level;
  reg  [3:0]    state;
  reg  [7:0]    sh;
  reg  [2:0]    bitn;
  reg  [7:0]    rd_byte;
  reg           ovf;
  reg           unf;
  reg           rx_mode;
  reg  [5:0]    tx_left;
  reg           wl_prev;
  wire          fifo_busy = (state == S_LOAD) || (state == S_READ); // RULE8 RULE9
  wire          byte_done = sclk_fal && (bitn == 3'h7);
  wire [7:0]    next_sh   = {sh[6:0], mosi_s[1]};
  wire          clear_cmd = (state == S_HEAD) && byte_done && next_sh[7:6] == `SPI_MODE_CMD &&
                            ({next_sh[7:1], 1'b0} == `CMD_CLEAR_A);
  wire          full      = (level == DEPTH);
  wire          empty     = (level == 0);

  // Receive words pass the skid buffer so a busy FIFO write port stalls the framer, not drops
  wire [7:0] rx_word;
  wire [7:0] buf_data;
  wire       buf_valid;
  wire       host_wr   = (state == S_LOAD) && byte_done;
  wire       host_rd   = (state == S_READ) && byte_done;
  wire       buf_ready = ~host_wr;

  // RULE16 RULE25: byte framing drops parity, bit-stream keeps all bits, zero padded
  wire       par_ok    = rx_bitstream || (^rx_air_byte[8:0]);
  assign rx_word = rx_bitstream ? (rev8(rx_air_byte[7:0]) & ~(8'hff >> rx_air_bits)) // RULE18
                                : rx_air_byte[7:0]; // RULE17

  two_entry_buffer #(.WIDTH(8)) rx_buf (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .flush     (clear_cmd),
    .in_data   (rx_word),
    .in_valid  (rx_air_valid && par_ok),
    .in_ready  (rx_air_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  wire rx_push  = buf_valid && buf_ready;
  wire tx_pop   = tx_active && !tx_air_valid && !host_rd;
  wire do_write = host_wr || rx_push;
  wire do_read  = host_rd || tx_pop;

  always @(posedge core_clk) begin
    if (clk_en && do_write && !full)
      mem[wr_ptr] <= host_wr ? next_sh : buf_data;
  end

  // Serial frame decode and FIFO pointers
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      sh <= 8'h00;
      bitn <= 3'h0;
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      ovf <= 1'b0;
      unf <= 1'b0;
      rd_byte <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      tx_active <= 1'b0;
      tx_left <= 6'h00;
      tx_air_valid <= 1'b0;
      tx_air_byte <= 9'h000;
      rx_mode <= 1'b0;
      enter_halt_command <= 1'b0;
      set_default <= 1'b0;
    end else if (clk_en) begin
      enter_halt_command <= 1'b0;
      set_default <= 1'b0;
      if (ss_rise || !ss_low) begin
        state <= S_IDLE; // RULE9
        bitn <= 3'h0;
        miso_oe <= 1'b0;
      end else begin
        if (state == S_IDLE)
          state <= S_HEAD;
        if (sclk_fal) begin
          sh <= next_sh;
          bitn <= bitn + 3'h1;
        end
        if (sclk_ris && state == S_READ) begin
          miso <= rd_byte[3'h7 - bitn]; // RULE17
          miso_oe <= 1'b1;
        end
      end
      if (state == S_HEAD && byte_done && ss_low) begin
        case (next_sh[7:6])
          `SPI_MODE_FIFO: begin // RULE23
            if (next_sh[5:0] == `SPI_FIFO_LOAD)
              state <= S_LOAD;
            else if (next_sh[5:0] == `SPI_FIFO_READ)
              state <= S_READ;
            else
              state <= S_HEAD;
          end
          `SPI_MODE_CMD: begin // RULE24
            if (next_sh == `CMD_DEFAULT_A || next_sh == `CMD_DEFAULT_B)
              set_default <= 1'b1; // RULE19
            if (next_sh == `CMD_TRANSMIT && field_power_on_threshold &&
                (proto_mode == `MODE_L4 || proto_mode[1])) begin // RULE21
              tx_active <= 1'b1;
              tx_left <= tx_byte_count;
              rx_mode <= 1'b0;
            end
            if (next_sh == `CMD_HALT && field_power_on_threshold && !proto_mode[1])
              enter_halt_command <= 1'b1; // RULE22
          end
          default: state <= S_HEAD;
        endcase
      end
      if (tx_air_valid && tx_air_ready)
        tx_air_valid <= 1'b0;
      if (tx_pop) begin
        if (tx_left == 6'h00)
          tx_active <= 1'b0;
        else begin
          tx_left <= tx_left - 6'h01;
          tx_air_valid <= 1'b1;
          tx_air_byte <= tx_bitstream ? {1'b0, rev8(mem[rd_ptr])} // RULE18 RULE25
                                      : {~(^mem[rd_ptr]), mem[rd_ptr]}; // RULE16 RULE17
        end
      end
      if (host_rd)
        rd_byte <= empty ? 8'h00 : mem[rd_ptr];
      else if (state == S_HEAD && byte_done && next_sh == {`SPI_MODE_FIFO, `SPI_FIFO_READ})
        rd_byte <= empty ? 8'h00 : mem[rd_ptr];
      if (rx_push)
        rx_mode <= 1'b1;
      if (do_write && full)
        ovf <= 1'b1; // RULE14
      if ((do_read && !(tx_pop && tx_left == 6'h00)) && empty)
        unf <= 1'b1; // RULE15 RULE10
      if (do_write && !full)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (do_read && !empty && !(tx_pop && tx_left == 6'h00))
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      level <= level + {{AW{1'b0}}, (do_write && !full)}
                     - {{AW{1'b0}}, (do_read && !empty && !(tx_pop && tx_left == 6'h00))}; // RULE13
      if (clear_cmd) begin // RULE20
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        level <= {(AW+1){1'b0}};
        tx_active <= 1'b0;
        tx_air_valid <= 1'b0;
        ovf <= 1'b0;
        unf <= 1'b0;
      end
      if (set_default) begin
        tx_active <= 1'b0;
        ovf <= 1'b0;
        unf <= 1'b0;
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        level <= {(AW+1){1'b0}};
      end
    end
  end

  assign fifo_status1 = {{(7-AW){1'b0}}, level};
  assign fifo_status2 = {6'h00, ovf, unf};

  // Water level compares the level only while the serial side is not touching the FIFO
  wire wl_cond = tx_active ? (level <= `WL_TX_LEVEL) // RULE6
                           : (rx_mode && level >= `WL_RX_LEVEL); // RULE7
  wire wl_hit  = wl_cond && !fifo_busy && !wl_prev; // RULE8 RULE11 RULE12
  reg  ovf_d;
  reg  unf_d;
  reg  par_err;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      main_irq <= 8'h00;
      aux_irq <= 8'h00;
      wl_prev <= 1'b0;
      ovf_d <= 1'b0;
      unf_d <= 1'b0;
      par_err <= 1'b0;
    end else if (clk_en) begin
      wl_prev <= fifo_busy ? 1'b0 : wl_cond;
      ovf_d <= ovf;
      unf_d <= unf;
      par_err <= rx_air_valid && rx_air_ready && !par_ok;
      // Set wins over a read in the same cycle
      main_irq[7:1] <= (rd_main_irq ? 7'h00 : main_irq[7:1]) // RULE3
                       | main_irq_event // RULE2
                       | ({6'h00, wl_hit} << (`IRQ_WL_BIT - 1)); // RULE1
      aux_irq <= (rd_aux_irq || set_default ? 8'h00 : aux_irq)
                 | {5'h00, par_err, unf & ~unf_d, ovf & ~ovf_d}; // RULE10
      if (|(aux_irq & ~{8{rd_aux_irq}}) || par_err || (unf & ~unf_d) || (ovf & ~ovf_d))
        main_irq[`IRQ_AUX_BIT] <= 1'b1; // RULE4
      else if (rd_aux_irq)
        main_irq[`IRQ_AUX_BIT] <= 1'b0;
      if (set_default)
        main_irq <= 8'h00;
    end
  end

  assign irq = |main_irq; // RULE5
endmodule

/* rtl/tag_fifo_consts.vh */
// Purpose: Constants for the tag FIFO, interrupt and command path
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef TAG_FIFO_CONSTS_VH
`define TAG_FIFO_CONSTS_VH
`define FIFO_DEPTH        32
`define FIFO_AW           5
`define WL_TX_LEVEL       6'h08
`define WL_RX_LEVEL       6'h18
`define SPI_MODE_FIFO     2'h2
`define SPI_MODE_CMD      2'h3
`define SPI_FIFO_LOAD     6'h00
`define SPI_FIFO_READ     6'h3f
`define CMD_DEFAULT_A     8'hc2
`define CMD_DEFAULT_B     8'hc3
`define CMD_CLEAR_A       8'hc4
`define CMD_CLEAR_B       8'hc5
`define CMD_TRANSMIT      8'hc8
`define CMD_HALT          8'hd0
`define MODE_L4           2'h0
`define MODE_L3           2'h1
`define IRQ_WL_BIT        3
`define IRQ_RXE_BIT       4
`define IRQ_TXE_BIT       5
`define IRQ_AUX_BIT       0
`define AUX_OVF_BIT       0
`define AUX_UNF_BIT       1
`define AUX_PAR_BIT       2
`endif

/* rtl/two_entry_buffer.v */
// Purpose: Two-entry skid buffer with valid/ready on both sides
// Assumes: Single clock, synchronous reset, clock enable
// Notes:   Full when both entries hold data; ready follows full
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,  // Clock
  input  wire             sys_rst,   // Sync reset
  input  wire             clk_en,    // Clock enable
  input  wire             flush,     // Drop contents
  input  wire [WIDTH-1:0] in_data,   // Fill data
  input  wire             in_valid,  // Fill valid
  output wire             in_ready,  // Room for a word
  output wire [WIDTH-1:0] out_data,  // Drain data
  output wire             out_valid, // Drain valid
  input  wire             out_ready  // Drain accepts
);
  reg [WIDTH-1:0] slot [0:1];
  reg             rd_ptr;
  reg             wr_ptr;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge core_clk) begin
    if (sys_rst || (clk_en && flush)) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        slot[wr_ptr] <= in_data;
        wr_ptr       <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule

/* tb/spi_host_model.sv */
// Purpose: Serial host model: select, link clock and data lines
// Assumes: Clock idles low; data set before rising, read at falling
// Notes:   Idle data line shows the inverse of the last bit sent
`timescale 1ns/1ps
module spi_host_model (
  output logic ss_n,   // Select, active low
  output logic sclk,   // Link clock
  output logic mosi,   // Data to device
  input  wire  miso,   // Data from device
  input  wire  miso_oe // Device drives miso
);
  logic last;
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    last = 1'b1;
  end
  // Select is released right after the last byte, never left low
  task sel(input logic on);
    begin
      #100;
      ss_n = ~on;
      mosi = ~last;
      #100;
    end
  endtask
  // One byte, top bit first, link clock period 125 ns
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        mosi = tx[i];
        last = tx[i];
        #31.25 sclk = 1'b1;
        #62.5 sclk = 1'b0;
        rx[i] = miso_oe ? miso : ~miso;
        #31.25;
      end
    end
  endtask
endmodule

/* tb/tag_fifo_irq_command_ctrl_chk.sv */
// Purpose: Assertions on interrupt flags, FIFO status and commands
// Assumes: Sees top ports only; clock enable held high
// Notes:   Flag timing allows a short internal pipeline
`timescale 1ns/1ps
`include "tag_fifo_consts.vh"
module tag_fifo_irq_command_ctrl_chk #(
  parameter DEPTH = 32
) (
  input wire       core_clk,                 // Clock
  input wire       sys_rst,                  // Reset
  input wire       irq,                      // Request
  input wire [7:0] main_irq,                 // Main flags
  input wire [7:0] aux_irq,                  // Aux flags
  input wire       rd_main_irq,              // Main read
  input wire       rd_aux_irq,               // Aux read
  input wire [6:0] main_irq_event,           // Events
  input wire [7:0] fifo_status1,             // Level
  input wire [7:0] fifo_status2,             // Errors
  input wire       rx_air_valid,             // Rx strobe
  input wire       tx_active,                // Tx busy
  input wire [8:0] tx_air_byte,              // Tx byte
  input wire       tx_air_valid,             // Tx valid
  input wire       tx_air_ready,             // Tx ready
  input wire       tx_bitstream,             // Tx raw
  input wire       field_power_on_threshold, // Field
  input wire [1:0] proto_mode,               // Mode
  input wire       enter_halt_command        // Halt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_irq_is_or: assert property (irq == (|main_irq))
    else $error("irq differs from flag OR");
  a_event_sets: assert property ((main_irq_event != 7'h00) |=>
    ((main_irq[7:1] & $past(main_irq_event)) == $past(main_irq_event))) else $error("event flag not set");
  a_main_read_clear: assert property (rd_main_irq && main_irq_event == 7'h00 |=> (main_irq & 8'hf6) == 8'h00)
    else $error("main read left flags");
  a_aux_pend_kept: assert property (rd_main_irq && !rd_aux_irq && main_irq[0] |=> main_irq[0])
    else $error("pending flag lost on main read");
  a_aux_read_clear: assert property (rd_aux_irq && !rx_air_valid && !tx_active |=> aux_irq == 8'h00)
    else $error("aux read left flags");
  a_level_bound: assert property (fifo_status1 <= DEPTH)
    else $error("level above depth");
  a_ovf_flags: assert property ($rose(fifo_status2[1]) |-> ##[0:3] aux_irq[0])
    else $error("overflow without aux flag");
  a_unf_flags: assert property ($rose(fifo_status2[0]) |-> ##[0:3] (aux_irq[1] && main_irq[0]))
    else $error("underflow without flags");
  a_tx_parity: assert property (tx_air_valid && !tx_bitstream |-> tx_air_byte[8] == ~^tx_air_byte[7:0])
    else $error("tx parity wrong");
  a_tx_hold: assert property (tx_air_valid && !tx_air_ready |=> tx_air_valid && $stable(tx_air_byte))
    else $error("tx byte dropped");
  a_halt_gate: assert property (enter_halt_command |-> $past(field_power_on_threshold) && !$past(proto_mode[1]))
    else $error("halt outside field or mode");
  a_tx_gate: assert property ($rose(tx_active) |-> $past(field_power_on_threshold) && $past(proto_mode) != `MODE_L3)
    else $error("tx start not allowed");
  c_aux_read: cover property (rd_aux_irq && main_irq[0]);
  c_halt: cover property (enter_halt_command);
  c_tx: cover property (tx_air_valid && tx_air_ready);
endmodule

/* tb/tag_fifo_irq_command_ctrl_tb.sv */
// Purpose: Self-checking bench for tag FIFO, interrupts and commands
// Assumes: Host model drives the serial pins at 125 ns link period
// Notes:   Bit-stream options stay off; rx bytes are always full
`timescale 1ns/1ps
`include "tag_fifo_consts.vh"
module tag_fifo_irq_command_ctrl_tb;
  logic       core_clk, sys_rst, clk_en, ss_n, sclk, mosi, miso, miso_oe, irq, rd_main_irq, rd_aux_irq;
  logic       rx_bitstream, tx_bitstream, field_power_on_threshold, rx_air_valid, rx_air_ready;
  logic       tx_air_valid, tx_air_ready, tx_active, enter_halt_command, set_default;
  logic [7:0] main_irq, aux_irq, fifo_status1, fifo_status2, got;
  logic [6:0] main_irq_event;
  logic [1:0] proto_mode;
  logic [5:0] tx_byte_count;
  logic [8:0] rx_air_byte, tx_air_byte, b;
  logic [3:0] rx_air_bits;
  int         n_errors = 0, checks_done = 0, n_halt = 0, n_def = 0, i;
  tag_fifo_irq_command_ctrl u_tag_fifo_irq_command_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .irq(irq), .rd_main_irq(rd_main_irq), .rd_aux_irq(rd_aux_irq),
    .main_irq(main_irq), .aux_irq(aux_irq), .main_irq_event(main_irq_event), .fifo_status1(fifo_status1),
    .fifo_status2(fifo_status2), .proto_mode(proto_mode), .rx_bitstream(rx_bitstream),
    .tx_bitstream(tx_bitstream), .field_power_on_threshold(field_power_on_threshold),
    .tx_byte_count(tx_byte_count), .rx_air_byte(rx_air_byte), .rx_air_bits(rx_air_bits),
    .rx_air_valid(rx_air_valid), .rx_air_ready(rx_air_ready), .tx_air_byte(tx_air_byte),
    .tx_air_valid(tx_air_valid), .tx_air_ready(tx_air_ready), .tx_active(tx_active),
    .enter_halt_command(enter_halt_command), .set_default(set_default));
  spi_host_model u_host (.ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (enter_halt_command === 1'b1) n_halt <= n_halt + 1;
    if (set_default === 1'b1) n_def <= n_def + 1;
  end
  task results;
    begin
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task check(input logic [8:0] seen, input logic [8:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tmo;
    begin
      $display("CHECK FAILED at %0t: wait ran out", $time);
      n_errors = n_errors + 1;
      results();
    end
  endtask
  task tick(input int n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // Whole frames only; a partial byte would be discarded by the device
  task frame(input logic [7:0] h, input logic [7:0] d, input logic two);
    begin
      u_host.sel(1'b1);
      u_host.xfer(h, got);
      if (two) u_host.xfer(d, got);
      u_host.sel(1'b0);
      tick(10);
    end
  endtask
  task rd(input logic aux);
    begin
      @(posedge core_clk);
      rd_main_irq <= ~aux;
      rd_aux_irq  <= aux;
      @(posedge core_clk);
      rd_main_irq <= 1'b0;
      rd_aux_irq  <= 1'b0;
      tick(2);
    end
  endtask
  task wlev(input logic [7:0] e);
    int k;
    begin
      k = 0;
      while (fifo_status1 !== e && k < 100) begin
        k = k + 1;
        tick(1);
      end
      check(fifo_status1, e);
    end
  endtask
  task rx_push(input logic [8:0] v);
    int k;
    begin
      @(posedge core_clk);
      rx_air_byte  <= v;
      rx_air_valid <= 1'b1;
      k = 0;
      @(negedge core_clk);
      while (rx_air_ready !== 1'b1 && k < 200) begin
        k = k + 1;
        @(negedge core_clk);
      end
      if (k >= 200) tmo();
      @(posedge core_clk);
      rx_air_valid <= 1'b0;
    end
  endtask
  // Receiver stalls a few cycles before taking each byte
  task tx_pull(output logic [8:0] v);
    int k;
    begin
      k = 0;
      while (tx_air_valid !== 1'b1 && k < 500) begin
        k = k + 1;
        @(negedge core_clk);
      end
      if (k >= 500) tmo();
      tick(5);
      v = tx_air_byte;
      tx_air_ready <= 1'b1;
      @(posedge core_clk);
      tx_air_ready <= 1'b0;
      tick(1);
    end
  endtask
  initial begin
    sys_rst = 1'b1; clk_en = 1'b1; rd_main_irq = 1'b0; rd_aux_irq = 1'b0; main_irq_event = 7'h00;
    proto_mode = `MODE_L4; rx_bitstream = 1'b0; tx_bitstream = 1'b0; field_power_on_threshold = 1'b0;
    tx_byte_count = 6'h00; rx_air_byte = 9'h000; rx_air_bits = 4'h8; rx_air_valid = 1'b0; tx_air_ready = 1'b0;
    tick(4);
    sys_rst <= 1'b0;
    tick(3);
    check(irq, 1'b0);
    main_irq_event <= 7'h40;
    tick(1);
    main_irq_event <= 7'h00;
    tick(2);
    check(main_irq, 8'h80);
    check(irq, 1'b1);
    rd(1'b0);
    check(main_irq, 8'h00);
    $display("event test done");
    frame({`SPI_MODE_FIFO, `SPI_FIFO_READ}, 8'h00, 1'b1);
    check(fifo_status2[0], 1'b1);
    check(aux_irq[`AUX_UNF_BIT], 1'b1);
    rd(1'b0);
    check(main_irq, 8'h01);
    check(irq, 1'b1);
    rd(1'b1);
    check(aux_irq, 8'h00);
    check(main_irq, 8'h00);
    check(irq, 1'b0);
    $display("underflow test done");
    for (i = 1; i <= 24; i++) rx_push({~^i[7:0], i[7:0]});
    wlev(8'h18);
    // Water-level flag is registered one edge after the level shows 24
    tick(3);
    check(main_irq[`IRQ_WL_BIT], 1'b1);
    rd(1'b0);
    frame({`SPI_MODE_FIFO, `SPI_FIFO_READ}, 8'h00, 1'b1);
    check(got, 8'h01);
    wlev(8'h17);
    check(main_irq[`IRQ_WL_BIT], 1'b0);
    rx_push({^8'h55, 8'h55});
    tick(10);
    check(aux_irq[`AUX_PAR_BIT], 1'b1);
    wlev(8'h17);
    for (i = 0; i < 10; i++) rx_push({~^8'h33, 8'h33});
    // Last byte still sits in the skid buffer when the handshake ends
    tick(3);
    wlev(8'h20);
    check(fifo_status2[1], 1'b1);
    $display("receive test done");
    for (i = 0; i < 2; i++) begin
      frame(i ? `CMD_CLEAR_B : `CMD_CLEAR_A, 8'h00, 1'b0);
      wlev(8'h00);
      check(fifo_status2[1:0], 2'h0);
      frame({`SPI_MODE_FIFO, `SPI_FIFO_LOAD}, 8'h11, 1'b1);
      wlev(8'h01);
    end
    rd(1'b0);
    rd(1'b1);
    frame(`CMD_CLEAR_A, 8'h00, 1'b0);
    tx_byte_count <= 6'h02;
    frame({`SPI_MODE_FIFO, `SPI_FIFO_LOAD}, 8'ha5, 1'b1);
    frame({`SPI_MODE_FIFO, `SPI_FIFO_LOAD}, 8'h3c, 1'b1);
    wlev(8'h02);
    frame(`CMD_TRANSMIT, 8'h00, 1'b0);
    check(tx_active, 1'b0);
    field_power_on_threshold <= 1'b1;
    proto_mode <= `MODE_L3;
    frame(`CMD_TRANSMIT, 8'h00, 1'b0);
    check(tx_active, 1'b0);
    proto_mode <= `MODE_L4;
    frame(`CMD_TRANSMIT, 8'h00, 1'b0);
    tx_pull(b);
    check(b, {~^8'ha5, 8'ha5});
    tx_pull(b);
    check(b, {~^8'h3c, 8'h3c});
    tick(30);
    check(main_irq[`IRQ_WL_BIT], 1'b1);
    check(fifo_status2[0], 1'b0);
    $display("transmit test done");
    proto_mode <= 2'h2;
    frame(`CMD_HALT, 8'h00, 1'b0);
    check(n_halt[8:0], 9'h000);
    proto_mode <= `MODE_L3;
    frame(`CMD_HALT, 8'h00, 1'b0);
    check(n_halt[8:0], 9'h001);
    field_power_on_threshold <= 1'b0;
    frame(`CMD_HALT, 8'h00, 1'b0);
    check(n_halt[8:0], 9'h001);
    frame({`SPI_MODE_FIFO, `SPI_FIFO_LOAD}, 8'h22, 1'b1);
    frame(`CMD_DEFAULT_A, 8'h00, 1'b0);
    frame(`CMD_DEFAULT_B, 8'h00, 1'b0);
    check(n_def[8:0], 9'h002);
    wlev(8'h00);
    $display("command test done");
    results();
  end
endmodule
bind tag_fifo_irq_command_ctrl tag_fifo_irq_command_ctrl_chk #(.DEPTH(DEPTH)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .irq(irq), .main_irq(main_irq), .aux_irq(aux_irq),
  .rd_main_irq(rd_main_irq), .rd_aux_irq(rd_aux_irq), .main_irq_event(main_irq_event),
  .fifo_status1(fifo_status1), .fifo_status2(fifo_status2), .rx_air_valid(rx_air_valid),
  .tx_active(tx_active), .tx_air_byte(tx_air_byte), .tx_air_valid(tx_air_valid), .tx_air_ready(tx_air_ready),
  .tx_bitstream(tx_bitstream), .field_power_on_threshold(field_power_on_threshold), .proto_mode(proto_mode),
  .enter_halt_command(enter_halt_command));
